// >>> hw/nvc_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "nvc_defines.vh"

// How it works
// - signature row reads only, writes rejected
// - user row untouched by whole-chip erase
// - port reads user row unlocked only; writes always when locked, by armed mode when unlocked
// - fuses loaded into config during start-up
// - flash at 0x0000 code, 0x8000 data
// - code address is extension bit 0 above pointer
// - code-space word writes ignore pointer bit 0
// - code read: bit 0 picks byte
// - target address latched when operation starts
// - data window selects 32 KB flash block
// - reads stall while write or erase runs
// - byte per data store, word per code write
// - erase up to 32 pages, fixed duration
// - eeprom byte erase up to 32, byte writes
// - user row page erase, byte write, locked page
// - fuses byte granular, programming port only
// - chip/eeprom erase immediate, others arm mode
// - eeprom reachable through data space only
// - command accepted within four instructions of key
// - armed command persists until the next accepted write
// - program mode: each flash or user row write programs
// - page erase per write; cpu halted
// - flash page holds 512 bytes
module nvc_ctrl #(
  parameter [23:0] FL_WR_CYC = `NVC_CYC_UP(`NVC_FL_WR_NS),
  parameter [23:0] FL_ER_CYC = `NVC_CYC_UP(`NVC_FL_ER_NS),
  parameter [23:0] EE_WR_CYC = `NVC_CYC_UP(`NVC_EE_WR_NS),
  parameter [23:0] EE_ER_CYC = `NVC_CYC_UP(`NVC_EE_ER_NS),
  parameter [23:0] EE_ERWR_CYC = `NVC_CYC_UP(`NVC_EE_ERWR_NS),
  parameter [23:0] EE_FULL_CYC = `NVC_CYC_UP(`NVC_EE_FULL_NS)
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // processor access
  input wire cpu_instr_done,
  input wire cpu_req,
  input wire cpu_code_space,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_ptr_ext,
  input wire [15:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  output reg cpu_ready,
  output wire cpu_halt,
  // programming port access
  input wire pp_req,
  input wire pp_we,
  input wire [15:0] pp_addr,
  input wire [7:0] pp_wdata,
  input wire dev_locked,
  output reg [7:0] pp_rdata,
  output reg pp_ready,
  // memory arrays
  output reg arr_start,
  output reg arr_rd,
  output reg [2:0] arr_target,
  output reg [2:0] arr_op,
  output reg [16:0] arr_addr,
  output reg [15:0] arr_wdata,
  output reg arr_word,
  output reg [5:0] arr_span,
  input wire [15:0] arr_rdata,
  // configuration from fuses
  output reg [63:0] fuse_cfg,
  output reg startup_done
);

  localparam [2:0] S_BOOT = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_RD1 = 3'h3;
  localparam [2:0] S_RD2 = 3'h4;
  localparam [2:0] S_ACK = 3'h5;

  // map a request address onto a target and its array address
  function [19:0] nvc_decode;
    input code;
    input [15:0] a;
    input [7:0] ext;
    input [1:0] w;
    begin
      if (code) begin
        nvc_decode = {`NVC_TGT_FLASH, ext[0], a};
      end else if (a >= `NVC_DS_FLASH) begin
        nvc_decode = {`NVC_TGT_FLASH, w, a[14:0]};
      end else if (a >= `NVC_DS_EE && a < `NVC_DS_EE + `NVC_EE_SIZE) begin
        nvc_decode = {`NVC_TGT_EEPROM, 8'h00, a[8:0]};
      end else if (a >= `NVC_DS_USER && a < `NVC_DS_USER + `NVC_USER_SIZE) begin
        nvc_decode = {`NVC_TGT_USER, 12'h000, a[4:0]};
      end else if (a >= `NVC_DS_SIG && a < `NVC_DS_SIG + `NVC_SIG_SIZE) begin
        nvc_decode = {`NVC_TGT_SIG, 10'h000, a[6:0]};
      end else if (a >= `NVC_DS_FUSE && a < `NVC_DS_FUSE + `NVC_FUSE_SIZE) begin
        nvc_decode = {`NVC_TGT_FUSE, 14'h0000, a[2:0]};
      end else begin
        nvc_decode = {`NVC_TGT_NONE, 17'h00000};
      end
    end
  endfunction

  // clear the address bits below a span boundary
  function [16:0] nvc_clear_low;
    input [16:0] a;
    input [3:0] n;
    begin
      nvc_clear_low = a & ~((17'h00001 << n) - 17'h00001);
    end
  endfunction

  reg [6:0] cmd;
  reg [1:0] win;
  reg [2:0] key_cnt;
  reg imm_pend;
  reg [2:0] imm_op;
  reg d_wr;
  reg [7:0] d_addr;
  reg [31:0] next_hrdata;
  reg [2:0] state;
  reg booting;
  reg [2:0] boot_idx;
  reg src_pp;
  reg cur_code;
  reg cur_we;
  reg [15:0] cur_addr;
  reg [7:0] cur_ext;
  reg [15:0] cur_wdata;
  reg fl_start;
  reg ee_start;
  reg [23:0] fl_load;
  reg [23:0] ee_load;
  reg fl_erasing;
  reg ee_full;
  reg w_ok;
  reg w_fl;
  reg [2:0] w_op;
  reg [16:0] w_addr;
  reg [5:0] w_span;
  reg w_word;
  reg [23:0] w_load;
  wire fl_busy_t;
  wire ee_busy_t;
  wire fl_busy;
  wire ee_busy;
  wire any_busy;
  wire [19:0] dec;
  wire [2:0] dec_tgt;
  wire [16:0] dec_addr;
  wire [7:0] rd_byte;
  wire imm_take;
  wire bus_sel;

  // a start pulse counts as busy so no second operation slips in
  assign fl_busy = fl_busy_t | fl_start;
  assign ee_busy = ee_busy_t | ee_start;
  assign any_busy = fl_busy | ee_busy;
  assign cpu_halt = (fl_busy & fl_erasing) | (ee_busy & ee_full);
  assign dec = nvc_decode(cur_code, cur_addr, cur_ext, win);
  assign dec_tgt = dec[19:17];
  assign dec_addr = dec[16:0];
  assign rd_byte = arr_addr[0] ? arr_rdata[15:8] : arr_rdata[7:0];
  assign imm_take = (state == S_IDLE) && imm_pend && !any_busy;
  assign bus_sel = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  nvc_op_timer u_fl_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .start(fl_start),
    .load(fl_load),
    .busy(fl_busy_t)
  );

  nvc_op_timer u_ee_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .start(ee_start),
    .load(ee_load),
    .busy(ee_busy_t)
  );

  // register read mux, sampled in the address phase
  always @* begin
    case (haddr[7:0])
      `NVC_OFS_CONTROL_REGISTER_A: next_hrdata = {25'h0000000, cmd};
      `NVC_OFS_CONTROL_REGISTER_B: next_hrdata = {30'h00000000, win};
      `NVC_OFS_STATUS: next_hrdata = {28'h0000000, cpu_halt, startup_done, ee_busy, fl_busy};
      `NVC_OFS_KEY: next_hrdata = {29'h00000000, key_cnt};
      default: next_hrdata = 32'h00000000;
    endcase
  end

  // bus slave: zero wait, read data stands through the data phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_wr <= 1'b0;
      d_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      d_wr <= bus_sel & hwrite;
      if (bus_sel) begin
        d_addr <= haddr[7:0];
      end
      if (bus_sel && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // control registers, key window and immediate erase request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= `NVC_CMD_NO_ACTION;
      win <= 2'h0;
      key_cnt <= 3'h0;
      imm_pend <= 1'b0;
      imm_op <= `NVC_OP_CHIP;
    end else begin
      if (d_wr && d_addr == `NVC_OFS_KEY && hwdata[7:0] == `NVC_KEY) begin
        key_cnt <= `NVC_KEY_WINDOW;
      end else if (cpu_instr_done && key_cnt != 3'h0) begin
        key_cnt <= key_cnt - 3'h1;
      end
      if (d_wr && d_addr == `NVC_OFS_CONTROL_REGISTER_B) begin
        win <= hwdata[1:0];
      end
      // command held until the next accepted write; a new request beats a take
      if (d_wr && d_addr == `NVC_OFS_CONTROL_REGISTER_A && key_cnt != 3'h0) begin
        cmd <= hwdata[6:0];
        if (hwdata[6:0] == `NVC_CMD_WHOLE_CHIP_ERASE) begin
          imm_pend <= 1'b1;
          imm_op <= `NVC_OP_CHIP;
        end else if (hwdata[6:0] == `NVC_CMD_EEPROM_FULL_ERASE) begin
          imm_pend <= 1'b1;
          imm_op <= `NVC_OP_EE_FULL;
        end else if (imm_take) begin
          imm_pend <= 1'b0;
        end
      end else if (imm_take) begin
        imm_pend <= 1'b0;
      end
    end
  end

  // what an array write does under the armed command
  always @* begin
    w_ok = 1'b0;
    w_fl = 1'b1;
    w_op = `NVC_OP_WRITE;
    w_addr = dec_addr;
    w_span = 6'h01;
    w_word = 1'b0;
    w_load = FL_WR_CYC;
    case (dec_tgt)
      `NVC_TGT_FLASH: begin
        if (cmd == `NVC_CMD_FLASH_PROGRAM) begin
          w_ok = 1'b1;
          w_word = cur_code;
          w_addr = cur_code ? {dec_addr[16:1], 1'b0} : dec_addr;
        end else if (cmd[6:3] == `NVC_CMD_FLASH_ERASE_GRP && cmd[2:0] <= `NVC_SPAN_MAX_LOG) begin
          w_ok = 1'b1;
          w_op = `NVC_OP_ERASE;
          w_addr = nvc_clear_low(dec_addr, `NVC_PAGE_LSB + {1'b0, cmd[2:0]});
          w_span = 6'h01 << cmd[2:0];
          w_load = FL_ER_CYC;
        end
      end
      `NVC_TGT_USER: begin
        if (src_pp && dev_locked) begin
          // locked port: first byte of the row erases the whole row first
          w_ok = 1'b1;
          if (dec_addr[4:0] == 5'h00) begin
            w_op = `NVC_OP_ERASE_WRITE;
            w_span = `NVC_USER_SPAN;
            w_load = FL_ER_CYC;
          end
        end else if (cmd == `NVC_CMD_FLASH_PROGRAM) begin
          w_ok = 1'b1;
        end else if (cmd[6:3] == `NVC_CMD_FLASH_ERASE_GRP && cmd[2:0] <= `NVC_SPAN_MAX_LOG) begin
          w_ok = 1'b1;
          w_op = `NVC_OP_ERASE;
          w_addr = nvc_clear_low(dec_addr, `NVC_USER_LSB);
          w_span = `NVC_USER_SPAN;
          w_load = FL_ER_CYC;
        end
      end
      `NVC_TGT_EEPROM, `NVC_TGT_FUSE: begin
        w_fl = 1'b0;
        w_load = EE_WR_CYC;
        // fuses follow the eeprom modes but never for the processor
        if (dec_tgt == `NVC_TGT_EEPROM || src_pp) begin
          if (cmd == `NVC_CMD_EE_WRITE) begin
            w_ok = 1'b1;
          end else if (cmd == `NVC_CMD_EE_ERASE_WRITE) begin
            w_ok = 1'b1;
            w_op = `NVC_OP_ERASE_WRITE;
            w_load = EE_ERWR_CYC;
          end else if (cmd[6:3] == `NVC_CMD_EE_ERASE_GRP && cmd[2:0] <= `NVC_SPAN_MAX_LOG) begin
            w_ok = 1'b1;
            w_op = `NVC_OP_ERASE;
            w_addr = nvc_clear_low(dec_addr, {1'b0, cmd[2:0]});
            w_span = 6'h01 << cmd[2:0];
            w_load = EE_ER_CYC;
          end
        end
      end
      default: begin
        w_ok = 1'b0;
      end
    endcase
  end

  // access sequencer: fuse load, request service, immediate erases
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_BOOT;
      booting <= 1'b1;
      boot_idx <= 3'h0;
      src_pp <= 1'b0;
      cur_code <= 1'b0;
      cur_we <= 1'b0;
      cur_addr <= 16'h0000;
      cur_ext <= 8'h00;
      cur_wdata <= 16'h0000;
      fl_start <= 1'b0;
      ee_start <= 1'b0;
      fl_load <= 24'h000001;
      ee_load <= 24'h000001;
      fl_erasing <= 1'b0;
      ee_full <= 1'b0;
      arr_start <= 1'b0;
      arr_rd <= 1'b0;
      arr_target <= `NVC_TGT_NONE;
      arr_op <= `NVC_OP_WRITE;
      arr_addr <= 17'h00000;
      arr_wdata <= 16'h0000;
      arr_word <= 1'b0;
      arr_span <= 6'h01;
      cpu_rdata <= 8'h00;
      cpu_ready <= 1'b0;
      pp_rdata <= 8'h00;
      pp_ready <= 1'b0;
      fuse_cfg <= 64'h0000000000000000;
      startup_done <= 1'b0;
    end else begin
      arr_start <= 1'b0;
      arr_rd <= 1'b0;
      fl_start <= 1'b0;
      ee_start <= 1'b0;
      cpu_ready <= 1'b0;
      pp_ready <= 1'b0;
      case (state)
        S_BOOT: begin
          arr_rd <= 1'b1;
          arr_target <= `NVC_TGT_FUSE;
          arr_addr <= {14'h0000, boot_idx};
          state <= S_RD1;
        end
        S_IDLE: begin
          if (imm_take) begin
            arr_start <= 1'b1;
            arr_op <= imm_op;
            arr_addr <= 17'h00000;
            arr_span <= 6'h01;
            ee_start <= 1'b1;
            ee_load <= EE_FULL_CYC;
            ee_full <= 1'b1;
            if (imm_op == `NVC_OP_CHIP) begin
              // chip operation covers flash and eeprom, the user row is kept
              arr_target <= `NVC_TGT_FLASH;
              fl_start <= 1'b1;
              fl_load <= FL_ER_CYC;
              fl_erasing <= 1'b1;
            end else begin
              arr_target <= `NVC_TGT_EEPROM;
            end
          end else if (pp_req && !pp_ready) begin
            src_pp <= 1'b1;
            cur_code <= 1'b0;
            cur_we <= pp_we;
            cur_addr <= pp_addr;
            cur_ext <= 8'h00;
            cur_wdata <= {8'h00, pp_wdata};
            state <= S_WAIT;
          end else if (cpu_req && !cpu_ready) begin
            src_pp <= 1'b0;
            cur_code <= cpu_code_space;
            cur_we <= cpu_we;
            cur_addr <= cpu_addr;
            cur_ext <= cpu_ptr_ext;
            cur_wdata <= cpu_wdata;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // the request is held here while any operation runs
          if (!any_busy) begin
            if (!cur_we) begin
              if (dec_tgt == `NVC_TGT_NONE || (src_pp && dev_locked && dec_tgt == `NVC_TGT_USER)) begin
                pp_rdata <= 8'h00;
                state <= S_ACK;
              end else begin
                arr_rd <= 1'b1;
                arr_target <= dec_tgt;
                arr_addr <= dec_addr;
                state <= S_RD1;
              end
            end else begin
              if (w_ok) begin
                arr_start <= 1'b1;
                arr_target <= dec_tgt;
                arr_op <= w_op;
                arr_addr <= w_addr;
                arr_span <= w_span;
                arr_word <= w_word;
                arr_wdata <= w_word ? cur_wdata : {8'h00, cur_wdata[7:0]};
                if (w_fl) begin
                  fl_start <= 1'b1;
                  fl_load <= w_load;
                  fl_erasing <= (w_op != `NVC_OP_WRITE);
                end else begin
                  ee_start <= 1'b1;
                  ee_load <= w_load;
                  ee_full <= 1'b0;
                end
              end
              state <= S_ACK;
            end
          end
        end
        S_RD1: begin
          state <= S_RD2;
        end
        S_RD2: begin
          if (booting) begin
            fuse_cfg[{boot_idx, 3'h0} +: 8] <= rd_byte;
            boot_idx <= boot_idx + 3'h1;
            if (boot_idx == `NVC_FUSE_LAST) begin
              booting <= 1'b0;
              startup_done <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_BOOT;
            end
          end else begin
            if (src_pp) begin
              pp_rdata <= rd_byte;
            end else begin
              cpu_rdata <= rd_byte;
            end
            state <= S_ACK;
          end
        end
        S_ACK: begin
          pp_ready <= src_pp;
          cpu_ready <= !src_pp;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> shared/nvc_defines.vh
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH

// register byte offsets on the bus
`define NVC_OFS_CONTROL_REGISTER_A 8'h00
`define NVC_OFS_CONTROL_REGISTER_B 8'h04
`define NVC_OFS_STATUS 8'h08
`define NVC_OFS_KEY 8'h0C

// status bit positions
`define NVC_ST_FL_BUSY 0
`define NVC_ST_EE_BUSY 1
`define NVC_ST_BOOTED 2
`define NVC_ST_HALT 3

// protection key (value is arbitrary) and its instruction window
`define NVC_KEY 8'hA5
`define NVC_KEY_WINDOW 3'h4

// command codes; erase groups carry log2 of the span in bits 2:0
`define NVC_CMD_NO_ACTION 7'h00
`define NVC_CMD_FLASH_PROGRAM 7'h02
`define NVC_CMD_FLASH_ERASE_GRP 4'h1
`define NVC_CMD_EE_WRITE 7'h12
`define NVC_CMD_EE_ERASE_WRITE 7'h13
`define NVC_CMD_EE_ERASE_GRP 4'h3
`define NVC_CMD_WHOLE_CHIP_ERASE 7'h20
`define NVC_CMD_EEPROM_FULL_ERASE 7'h30
`define NVC_CMD_CLEAR 7'h7F
`define NVC_SPAN_MAX_LOG 3'h5

// array targets
`define NVC_TGT_FLASH 3'h0
`define NVC_TGT_EEPROM 3'h1
`define NVC_TGT_USER 3'h2
`define NVC_TGT_SIG 3'h3
`define NVC_TGT_FUSE 3'h4
`define NVC_TGT_NONE 3'h7

// array operations
`define NVC_OP_WRITE 3'h1
`define NVC_OP_ERASE 3'h2
`define NVC_OP_ERASE_WRITE 3'h3
`define NVC_OP_CHIP 3'h4
`define NVC_OP_EE_FULL 3'h5

// data-space map
`define NVC_DS_FLASH 16'h8000
`define NVC_DS_EE 16'h1400
`define NVC_EE_SIZE 16'h0200
`define NVC_DS_USER 16'h1080
`define NVC_USER_SIZE 16'h0020
`define NVC_DS_SIG 16'h1100
`define NVC_SIG_SIZE 16'h0080
`define NVC_DS_FUSE 16'h1050
`define NVC_FUSE_SIZE 16'h0008
`define NVC_FUSE_LAST 3'h7
`define NVC_PAGE_LSB 4'h9
`define NVC_USER_LSB 4'h5
`define NVC_USER_SPAN 6'h20

// operation times in ns, rounded up to clock cycles
`define NVC_CLK_PERIOD_NS 10
`define NVC_FL_WR_NS 40000
`define NVC_FL_ER_NS 8000000
`define NVC_EE_WR_NS 3000000
`define NVC_EE_ER_NS 3000000
`define NVC_EE_ERWR_NS 6000000
`define NVC_EE_FULL_NS 8000000
`define NVC_CYC_UP(ns) (((ns) + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)

`endif

// >>> hw/nvc_op_timer.v
`timescale 1ns/1ns
`default_nettype none

module nvc_op_timer (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // operation start and length in cycles (at least one)
  input wire start,
  input wire [23:0] load,
  // operation in progress
  output reg busy
);

  reg [23:0] cnt;

  // down counter; a start while busy is not expected, the controller waits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 24'h000000;
      busy <= 1'b0;
    end else if (start) begin
      cnt <= load;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 24'h000001;
      if (cnt <= 24'h000001) begin
        busy <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/nvc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module nvc_mem_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // array side of the controller
  input wire arr_rd,
  input wire [2:0] arr_target,
  input wire [16:0] arr_addr,
  output logic [15:0] arr_rdata
);
  // word = target and low offset bits, so row bases and offsets agree
  // stale data is inverted each cycle so a late sample never looks right
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_rdata <= 16'hFFFF;
    end else if (arr_rd) begin
      arr_rdata <= {arr_target, arr_addr[4:1], 1'b1, arr_target, arr_addr[4:1], 1'b0};
    end else begin
      arr_rdata <= ~arr_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> test/nvc_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module nvc_ctrl_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // access side
  input wire cpu_ready,
  input wire pp_ready,
  input wire pp_req,
  input wire cpu_halt,
  input wire startup_done,
  // array side
  input wire arr_start,
  input wire arr_rd,
  input wire [2:0] arr_target,
  input wire [2:0] arr_op,
  input wire [16:0] arr_addr,
  input wire arr_word,
  input wire [5:0] arr_span
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // array requests that must never appear
  a_sig_locked: assert property (arr_start |-> arr_target != 3'h3)
    else $error("signature row write started");
  a_user_kept: assert property (arr_start && arr_op == 3'h4 |-> arr_target != 3'h2)
    else $error("chip erase aimed at user row");
  a_fuse_port: assert property (arr_start && arr_target == 3'h4 |-> pp_req)
    else $error("fuse write not from programming port");
  a_word_even: assert property (arr_start && arr_word |-> !arr_addr[0] && arr_target == 3'h0)
    else $error("word write odd or off flash");
  a_span_pow: assert property (arr_start && arr_op == 3'h2 |->
    arr_span inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("erase span not a power of two up to 32");
  // flash erase stops the processor for a stretch
  a_erase_halt: assert property (arr_start && arr_target == 3'h0 && arr_op == 3'h2 |->
    ##[1:2] cpu_halt [*8])
    else $error("processor not halted by flash erase");
  a_halt_quiet: assert property (cpu_halt && $past(cpu_halt) |-> !arr_rd && !arr_start)
    else $error("array access while erase runs");
  a_boot_first: assert property (!startup_done |->
    !cpu_ready && !pp_ready && (!arr_rd || arr_target == 3'h4))
    else $error("access before fuse load ended");
  a_read_turn: assert property (arr_rd && startup_done |-> ##[2:4] (cpu_ready || pp_ready))
    else $error("read answer late");
endmodule
bind nvc_ctrl nvc_ctrl_monitor i_nvc_ctrl_monitor (
  .clk, .rst_n, .cpu_ready, .pp_ready, .pp_req, .cpu_halt, .startup_done,
  .arr_start, .arr_rd, .arr_target, .arr_op, .arr_addr, .arr_word, .arr_span
);
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "nvc_defines.vh"
module tb_top;
  localparam int FLW = 12;
  // design inputs, all set at time zero
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [2:0] hsize = 3'h0;
  logic cpu_instr_done = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_code_space = 1'b0;
  logic cpu_we = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_ptr_ext = 8'h00;
  logic [15:0] cpu_wdata = 16'h0000;
  logic pp_req = 1'b0;
  logic pp_we = 1'b0;
  logic [15:0] pp_addr = 16'h0000;
  logic [7:0] pp_wdata = 8'h00;
  logic dev_locked = 1'b1;
  // design outputs
  wire [31:0] hrdata;
  wire hreadyout, hresp, cpu_ready, cpu_halt, pp_ready, arr_start, arr_rd, arr_word, startup_done;
  wire [7:0] cpu_rdata, pp_rdata;
  wire [2:0] arr_target, arr_op;
  wire [16:0] arr_addr;
  wire [15:0] arr_wdata, arr_rdata;
  wire [5:0] arr_span;
  wire [63:0] fuse_cfg;
  // notes of expected results
  logic ahb_dp = 1'b0;
  logic [39:0] q_reg[$], q_rd[$], q_arr[$];
  int n_errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  // short operation times keep the run small; eeprom byte erase and erase-write modes are not run
  nvc_ctrl #(.FL_WR_CYC(24'h00000C), .FL_ER_CYC(24'h000014), .EE_WR_CYC(24'h00000A),
    .EE_FULL_CYC(24'h000014)) i_nvc_ctrl (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .cpu_instr_done, .cpu_req, .cpu_code_space, .cpu_we,
    .cpu_addr, .cpu_ptr_ext, .cpu_wdata, .cpu_rdata, .cpu_ready, .cpu_halt, .pp_req, .pp_we,
    .pp_addr, .pp_wdata, .dev_locked, .pp_rdata, .pp_ready, .arr_start, .arr_rd, .arr_target,
    .arr_op, .arr_addr, .arr_wdata, .arr_word, .arr_span, .arr_rdata, .fuse_cfg, .startup_done
  );
  nvc_mem_model i_nvc_mem_model (.clk, .rst_n, .arr_rd, .arr_target, .arr_addr, .arr_rdata);

  // array request as a note; fields an op leaves open are zeroed
  function automatic logic [39:0] rec(input logic [2:0] t, o, input logic [16:0] a,
    input logic w, input logic [15:0] d);
    logic [16:0] ma;
    logic [15:0] md;
    ma = (o == 3'h2) ? {a[16:9], 9'h000} : (o > 3'h3) ? 17'h00000 : a;
    md = (o == 3'h2 || o > 3'h3) ? 16'h0000 : w ? d : {8'h00, d[7:0]};
    rec = {t, o, ma, (o == 3'h1) && w, md};
  endfunction

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // watcher: each result meets the oldest note of its kind
  always @(posedge clk) begin
    if (ahb_dp) begin
      chk("hrdata", (q_reg.size() != 0) ? q_reg.pop_front() : '1, {8'h00, hrdata});
    end
    if ((cpu_ready && !cpu_we) || (pp_ready && !pp_we)) begin
      chk("rdata", (q_rd.size() != 0) ? q_rd.pop_front() : '1,
        {32'h00000000, cpu_ready ? cpu_rdata : pp_rdata});
    end
    if (arr_start) begin
      chk("arr", (q_arr.size() != 0) ? q_arr.pop_front() : '1,
        rec(arr_target, arr_op, arr_addr, arr_word, arr_wdata));
    end
  end

  // single word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic chk_it, output logic [31:0] v);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    ahb_dp <= chk_it && !wr;
    if (chk_it && !wr) q_reg.push_back({8'h00, d});
    do @(posedge clk); while (hreadyout !== 1'b1);
    ahb_dp <= 1'b0;
    v = hrdata;
  endtask

  // request held until its own ready pulse
  task automatic acc(input logic pp, code, we, input logic [15:0] a, d);
    @(posedge clk);
    if (pp) begin
      pp_req <= 1'b1;
      pp_we <= we;
      pp_addr <= a;
      pp_wdata <= d[7:0];
    end else begin
      cpu_req <= 1'b1;
      cpu_code_space <= code;
      cpu_we <= we;
      cpu_addr <= a;
      cpu_wdata <= d;
    end
    do @(posedge clk); while ((pp ? pp_ready : cpu_ready) !== 1'b1);
    pp_req <= 1'b0;
    cpu_req <= 1'b0;
  endtask

  task automatic rd(input logic pp, code, input logic [15:0] a, input logic [7:0] x);
    q_rd.push_back({32'h00000000, x});
    acc(pp, code, 1'b0, a, 16'h0000);
  endtask

  // key, then n retired instructions, then the command
  task automatic cmd(input logic [6:0] c, input int n);
    logic [31:0] v;
    ahb(1'b1, `NVC_OFS_KEY, {24'h000000, `NVC_KEY}, 1'b0, v);
    repeat (n) begin
      @(posedge clk);
      cpu_instr_done <= 1'b1;
      @(posedge clk);
      cpu_instr_done <= 1'b0;
    end
    ahb(1'b1, `NVC_OFS_CONTROL_REGISTER_A, {25'h0000000, c}, 1'b0, v);
  endtask

  task automatic idle;
    logic [31:0] v;
    do ahb(1'b0, `NVC_OFS_STATUS, 32'h00000000, 1'b0, v); while (v[1:0] !== 2'h0);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] v, r;
    logic [7:0] e;
    longint t0;
    v = $urandom(20945);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    do @(posedge clk); while (startup_done !== 1'b1);
    for (int i = 0; i < 8; i++) begin
      chk("fuse", {32'h00000000, 3'h4, i[4:0]}, {32'h00000000, fuse_cfg[8*i +: 8]});
    end
    ahb(1'b0, `NVC_OFS_STATUS, 32'h00000004, 1'b1, v);
    ahb(1'b0, 8'h10, 32'h00000000, 1'b1, v);
    // third retired instruction keeps the window open, fourth shuts it
    cmd(`NVC_CMD_FLASH_PROGRAM, 3);
    ahb(1'b0, `NVC_OFS_CONTROL_REGISTER_A, 32'h00000002, 1'b1, v);
    cmd(`NVC_CMD_CLEAR, 4);
    ahb(1'b0, `NVC_OFS_CONTROL_REGISTER_A, 32'h00000002, 1'b1, v);
    // program mode stays armed over two word writes at odd pointers
    e = $urandom;
    cpu_ptr_ext <= e;
    for (int k = 0; k < 2; k++) begin
      r = $urandom | 32'h00000001;
      q_arr.push_back(rec(3'h0, 3'h1, {e[0], r[15:1], 1'b0}, 1'b1, r[31:16]));
      acc(1'b0, 1'b1, 1'b1, r[15:0], r[31:16]);
      idle;
    end
    // byte store through window one, then a read that must wait it out
    ahb(1'b1, `NVC_OFS_CONTROL_REGISTER_B, 32'h00000001, 1'b0, v);
    r = $urandom;
    q_arr.push_back(rec(3'h0, 3'h1, 17'h08003, 1'b0, r[15:0]));
    acc(1'b0, 1'b0, 1'b1, 16'h8003, r[15:0]);
    t0 = $time;
    rd(1'b0, 1'b0, 16'h8005, 8'h05);
    chk("stall", 40'h0000000001, {39'h0000000000, ($time - t0) >= FLW * 10});
    cpu_ptr_ext <= 8'h00;
    rd(1'b0, 1'b1, 16'h0006, 8'h06);
    rd(1'b0, 1'b1, 16'h0007, 8'h07);
    // refused stores still answer and start nothing; accepted stores each start one operation
    cmd(`NVC_CMD_EE_WRITE, 0);
    acc(1'b0, 1'b0, 1'b1, 16'h1102, 16'h0055);
    acc(1'b0, 1'b0, 1'b1, 16'h1051, 16'h0055);
    rd(1'b0, 1'b0, 16'h1102, 8'h62);
    rd(1'b1, 1'b0, 16'h1102, 8'h62);
    rd(1'b1, 1'b0, 16'h1083, 8'h00);
    q_arr.push_back(rec(3'h1, 3'h1, 17'h00005, 1'b0, 16'h0077));
    acc(1'b0, 1'b0, 1'b1, 16'h1405, 16'h0077);
    q_arr.push_back(rec(3'h4, 3'h1, 17'h00001, 1'b0, 16'h005A));
    acc(1'b1, 1'b0, 1'b1, 16'h1051, 16'h005A);
    q_arr.push_back(rec(3'h2, 3'h3, 17'h00000, 1'b0, 16'h00C3));
    acc(1'b1, 1'b0, 1'b1, 16'h1080, 16'h00C3);
    dev_locked <= 1'b0;
    rd(1'b1, 1'b0, 16'h1083, 8'h43);
    // every flash erase group, then both immediate erases
    for (int n = 0; n < 6; n++) begin
      cmd({4'h1, n[2:0]}, 0);
      q_arr.push_back(rec(3'h0, 3'h2, 17'h08000, 1'b0, 16'h0000));
      acc(1'b0, 1'b0, 1'b1, 16'h8000, 16'h0000);
      idle;
    end
    q_arr.push_back(rec(3'h0, 3'h4, 17'h00000, 1'b0, 16'h0000));
    cmd(`NVC_CMD_WHOLE_CHIP_ERASE, 0);
    idle;
    q_arr.push_back(rec(3'h1, 3'h5, 17'h00000, 1'b0, 16'h0000));
    cmd(`NVC_CMD_EEPROM_FULL_ERASE, 0);
    idle;
    cmd(`NVC_CMD_NO_ACTION, 0);
    repeat (4) @(posedge clk);
    summarize;
  end

  // hang guard, many times the expected run
  initial begin
    #300000;
    n_errors++;
    summarize;
  end
endmodule
`default_nettype wire
